// *** common/timer_cmp_defines.vh ***
`ifndef TIMER_CMP_DEFINES_VH
`define TIMER_CMP_DEFINES_VH

// ****************************************
// bus and counter widths, register offsets
// ****************************************
`define ADDR_W 6
`define DATA_W 8
`define CNT_W 10
`define OFF_CTRL_A 6'h30
`define OFF_CTRL_C 6'h27
`define OFF_CTRL_D 6'h26
`define OFF_STATUS 6'h29

// ****************************************
// field positions
// ****************************************
`define F_MODE_A_HI 7
`define F_MODE_A_LO 6
`define F_MODE_B_HI 5
`define F_MODE_B_LO 4
`define F_PWM_A 1
`define F_PWM_B 0
`define F_WSEL_HI 1
`define F_WSEL_LO 0

// ****************************************
// reset values and codes
// ****************************************
`define RST_MODE 2'h0
`define RST_PWM 1'h0
`define RST_WSEL 2'h0
`define RST_CHAN_D 4'h0
`define RST_BYTE 8'h00
`define CODE_OFF 2'h0
`define CODE_TOGGLE 2'h1
`define CODE_CLEAR 2'h2
`define CODE_SET 2'h3
`define WSEL_FAST 2'h0
`define WSEL_PFC 2'h1
`define WSEL_SIX_SS 2'h2
`define WSEL_SIX_DS 2'h3
`define CNT_BOTTOM 10'h000

`endif

// *** hw/compare_detect.v ***
`timescale 1ns/1ps
`default_nettype none
`include "timer_cmp_defines.vh"

module compare_detect (
	// counter side
	input wire [`CNT_W-1:0] counter_value,
	input wire count_tick,
	// compare level
	input wire [`CNT_W-1:0] compare_value,
	// events
	output wire match,
	output wire bottom
);

	// only on a counter step, so a stalled counter does not retoggle
	// equality flags match
	assign match = count_tick & (counter_value == compare_value);
	assign bottom = count_tick & (counter_value == `CNT_BOTTOM);

endmodule
`default_nettype wire

// *** hw/wave_channel.v ***
`timescale 1ns/1ps
`default_nettype none
`include "timer_cmp_defines.vh"

module wave_channel (
	// clock and reset
	input wire core_clk,
	input wire resetn,
	// mode
	input wire pwm_en,
	input wire [1:0] wave_sel,
	input wire [1:0] out_mode,
	// events
	input wire match,
	input wire bottom,
	input wire count_down,
	// results
	output reg waveform,
	output wire true_conn,
	output wire comp_conn
);

	reg waveform_next;
	wire dual_slope;

	assign dual_slope = wave_sel[0];

	assign true_conn = |out_mode;
	assign comp_conn = pwm_en & (out_mode == `CODE_TOGGLE);

	// ****************************************
	// waveform update
	// ****************************************
	always @* begin
		waveform_next = waveform;
		if (out_mode != `CODE_OFF) begin
			if (!pwm_en) begin
				if (match) begin
					case (out_mode)
						`CODE_TOGGLE: waveform_next = ~waveform;
						`CODE_CLEAR: waveform_next = 1'b0;
						default: waveform_next = 1'b1;
					endcase
				end
			end else if (!dual_slope) begin
				if (bottom)
					waveform_next = (out_mode != `CODE_SET);
				if (match)
					waveform_next = (out_mode == `CODE_SET);
			end else begin
				if (match)
					waveform_next = (out_mode == `CODE_SET) ^ count_down;
			end
		end
	end

	always @(posedge core_clk) begin
		if (!resetn)
			waveform <= 1'b0;
		else
			waveform <= waveform_next;
	end

endmodule
`default_nettype wire

// *** hw/timer_compare_output.v ***
// Function
// - nonzero A code gives pin to compare
// - A complement only PWM code 01, or any nonzero A code in six-output
// - behaviour from PWM enable and select
// - non-PWM toggle, clear, set on match
// - fast PWM match and bottom actions
// - fast PWM code 01 connects both
// - dual slope up/down match actions
// - dual slope pin connections per code
// - single-slope six-output routes A everywhere
// - dual-slope six-output routes A everywhere
// - A mode and shadow bits identical
// - nonzero B code gives pin to compare
// - channel B same code meanings
// - B mode and shadow bits identical
// - PWM enable selects PWM operation
`timescale 1ns/1ps
`default_nettype none
`include "timer_cmp_defines.vh"

module timer_compare_output (
	// clock and reset
	input wire core_clk,
	input wire resetn,
	// register port
	input wire [`ADDR_W-1:0] reg_addr,
	input wire [`DATA_W-1:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [`DATA_W-1:0] reg_rdata,
	// counter core
	input wire [`CNT_W-1:0] counter_value,
	input wire count_tick,
	input wire count_down,
	input wire [`CNT_W-1:0] compare_value_a,
	input wire [`CNT_W-1:0] compare_value_b,
	// port logic, ordinary data and direction bits
	input wire port_data_a,
	input wire port_data_a_n,
	input wire port_data_b,
	input wire port_data_b_n,
	input wire dir_a,
	input wire dir_a_n,
	input wire dir_b,
	input wire dir_b_n,
	// pins
	output reg compare_pin_a,
	output reg compare_pin_a_oe,
	output reg compare_pin_a_n,
	output reg compare_pin_a_n_oe,
	output reg compare_pin_b,
	output reg compare_pin_b_oe,
	output reg compare_pin_b_n,
	output reg compare_pin_b_n_oe,
	// waveforms
	output wire waveform_out_a,
	output wire waveform_out_b
);

	// ****************************************
	// control state
	// ****************************************
	reg [1:0] chan_a_out_mode_reg;
	reg [1:0] chan_b_out_mode_reg;
	reg pwm_enable_a_reg;
	reg pwm_enable_b_reg;
	reg [1:0] wave_sel_reg;
	// channel D field only stored, so the shadow register reads back
	reg [3:0] chan_d_bits_reg;
	reg [1:0] chan_a_out_mode_next;
	reg [1:0] chan_b_out_mode_next;
	reg pwm_enable_a_next;
	reg pwm_enable_b_next;
	reg [1:0] wave_sel_next;
	reg [3:0] chan_d_bits_next;
	reg [`DATA_W-1:0] rdata_next;

	wire wave_sel_lo;
	wire wave_sel_hi;
	wire six_output_pwm;
	wire [1:0] pwm_en_vec;
	wire [3:0] mode_vec;
	wire [2*`CNT_W-1:0] cmp_vec;
	wire [1:0] match_vec;
	wire [1:0] bottom_vec;
	wire [1:0] wave_vec;
	wire [1:0] true_vec;
	wire [1:0] comp_vec;
	wire [`DATA_W-1:0] status_byte;

	assign wave_sel_lo = wave_sel_reg[0];
	assign wave_sel_hi = wave_sel_reg[1];

	// ****************************************
	// register decode
	// ****************************************
	function hit;
		input [`ADDR_W-1:0] addr;
		input [`ADDR_W-1:0] offset;
		begin
			hit = (addr == offset);
		end
	endfunction

	always @* begin
		chan_a_out_mode_next = chan_a_out_mode_reg;
		chan_b_out_mode_next = chan_b_out_mode_reg;
		pwm_enable_a_next = pwm_enable_a_reg;
		pwm_enable_b_next = pwm_enable_b_reg;
		wave_sel_next = wave_sel_reg;
		chan_d_bits_next = chan_d_bits_reg;
		if (reg_write) begin
			if (hit(reg_addr, `OFF_CTRL_A)) begin
				chan_a_out_mode_next =
					reg_wdata[`F_MODE_A_HI:`F_MODE_A_LO];
				chan_b_out_mode_next =
					reg_wdata[`F_MODE_B_HI:`F_MODE_B_LO];
				pwm_enable_a_next = reg_wdata[`F_PWM_A];
				pwm_enable_b_next = reg_wdata[`F_PWM_B];
				// force bits [3:2] dropped: no forced compare here
			end
			if (hit(reg_addr, `OFF_CTRL_C)) begin
				chan_a_out_mode_next =
					reg_wdata[`F_MODE_A_HI:`F_MODE_A_LO];
				chan_b_out_mode_next =
					reg_wdata[`F_MODE_B_HI:`F_MODE_B_LO];
				chan_d_bits_next = reg_wdata[3:0];
			end
			if (hit(reg_addr, `OFF_CTRL_D))
				wave_sel_next = reg_wdata[`F_WSEL_HI:`F_WSEL_LO];
		end
	end

	always @* begin
		rdata_next = `RST_BYTE;
		if (reg_read) begin
			// force bits are write-only and always read zero
			if (hit(reg_addr, `OFF_CTRL_A))
				rdata_next = {chan_a_out_mode_reg, chan_b_out_mode_reg,
					2'h0, pwm_enable_a_reg, pwm_enable_b_reg};
			else if (hit(reg_addr, `OFF_CTRL_C))
				rdata_next = {chan_a_out_mode_reg, chan_b_out_mode_reg,
					chan_d_bits_reg};
			else if (hit(reg_addr, `OFF_CTRL_D))
				rdata_next = {6'h00, wave_sel_hi, wave_sel_lo};
			else if (hit(reg_addr, `OFF_STATUS))
				rdata_next = status_byte;
		end
	end

	always @(posedge core_clk) begin
		if (!resetn) begin
			chan_a_out_mode_reg <= `RST_MODE;
			chan_b_out_mode_reg <= `RST_MODE;
			pwm_enable_a_reg <= `RST_PWM;
			pwm_enable_b_reg <= `RST_PWM;
			wave_sel_reg <= `RST_WSEL;
			chan_d_bits_reg <= `RST_CHAN_D;
			reg_rdata <= `RST_BYTE;
		end else begin
			chan_a_out_mode_reg <= chan_a_out_mode_next;
			chan_b_out_mode_reg <= chan_b_out_mode_next;
			pwm_enable_a_reg <= pwm_enable_a_next;
			pwm_enable_b_reg <= pwm_enable_b_next;
			wave_sel_reg <= wave_sel_next;
			chan_d_bits_reg <= chan_d_bits_next;
			reg_rdata <= rdata_next;
		end
	end

	// ****************************************
	// channels
	// ****************************************
	assign pwm_en_vec = {pwm_enable_b_reg, pwm_enable_a_reg};
	assign mode_vec = {chan_b_out_mode_reg, chan_a_out_mode_reg};
	assign cmp_vec = {compare_value_b, compare_value_a};

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
			compare_detect u_detect (
				.counter_value(counter_value),
				.count_tick(count_tick),
				.compare_value(cmp_vec[ch*`CNT_W +: `CNT_W]),
				.match(match_vec[ch]),
				.bottom(bottom_vec[ch])
			);
			wave_channel u_wave (
				.core_clk(core_clk),
				.resetn(resetn),
				.pwm_en(pwm_en_vec[ch]),
				.wave_sel(wave_sel_reg),
				.out_mode(mode_vec[ch*2 +: 2]),
				.match(match_vec[ch]),
				.bottom(bottom_vec[ch]),
				.count_down(count_down),
				.waveform(wave_vec[ch]),
				.true_conn(true_vec[ch]),
				.comp_conn(comp_vec[ch])
			);
		end
	endgenerate

	// ****************************************
	// waveform outputs
	// ****************************************
	assign waveform_out_a = wave_vec[0];
	assign waveform_out_b = wave_vec[1];

	// ****************************************
	// status view
	// ****************************************
	// live view, so software can see the routing it has just set up
	assign status_byte = {1'b0, six_output_pwm, compare_pin_b_oe,
		compare_pin_a_oe, comp_vec[1], comp_vec[0],
		wave_vec[1], wave_vec[0]};

	// ****************************************
	// pin routing
	// ****************************************
	// six-output takes every pair from channel A, whatever channel B says
	// six-output, single-slope and dual-slope
	assign six_output_pwm = pwm_enable_a_reg & wave_sel_hi & true_vec[0];

	// one mux shape for all four pins: compare value or port data
	function pin_sel;
		input over;
		input wave_val;
		input port_val;
		begin
			pin_sel = over ? wave_val : port_val;
		end
	endfunction

	reg over_a;
	reg over_a_n;
	reg over_b;
	reg over_b_n;
	reg val_b;

	always @* begin
		over_a = true_vec[0];
		over_a_n = comp_vec[0] | six_output_pwm;
		over_b = true_vec[1] | six_output_pwm;
		over_b_n = comp_vec[1] | six_output_pwm;
		val_b = six_output_pwm ? wave_vec[0] : wave_vec[1];
	end

	// pins registered so data outputs never glitch on mode writes
	always @(posedge core_clk) begin
		if (!resetn) begin
			compare_pin_a <= 1'b0;
			compare_pin_a_n <= 1'b0;
			compare_pin_b <= 1'b0;
			compare_pin_b_n <= 1'b0;
		end else begin
			compare_pin_a <= pin_sel(over_a, wave_vec[0], port_data_a);
			compare_pin_a_n <= pin_sel(over_a_n, ~wave_vec[0],
				port_data_a_n);
			compare_pin_b <= pin_sel(over_b, val_b, port_data_b);
			compare_pin_b_n <= pin_sel(over_b_n, ~val_b,
				port_data_b_n);
		end
	end

	// ****************************************
	// pin drivers
	// ****************************************
	// enables follow the direction bits only; a mode that takes a pin
	// still leaves it floating until software turns the driver on
	always @(posedge core_clk) begin
		if (!resetn) begin
			compare_pin_a_oe <= 1'b0;
			compare_pin_a_n_oe <= 1'b0;
			compare_pin_b_oe <= 1'b0;
			compare_pin_b_n_oe <= 1'b0;
		end else begin
			compare_pin_a_oe <= dir_a;
			compare_pin_a_n_oe <= dir_a_n;
			compare_pin_b_oe <= dir_b;
			compare_pin_b_n_oe <= dir_b_n;
		end
	end

endmodule
`default_nettype wire

// *** verif/timer_compare_output_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "timer_cmp_defines.vh"

module cmp_out_checker (
	// clock and reset
	input wire core_clk,
	input wire resetn,
	// register port
	input wire [`ADDR_W-1:0] reg_addr,
	input wire [`DATA_W-1:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	input wire [`DATA_W-1:0] reg_rdata,
	// counter and port
	input wire [`CNT_W-1:0] counter_value,
	input wire count_tick,
	input wire [`CNT_W-1:0] compare_value_a,
	input wire port_data_a,
	input wire port_data_a_n,
	input wire dir_a,
	input wire dir_b,
	// pins
	input wire compare_pin_a,
	input wire compare_pin_a_n,
	input wire compare_pin_a_oe,
	input wire compare_pin_b_oe,
	input wire waveform_out_a
);
	// ********
	// mode mirror
	// ********
	logic [1:0] mode_a;
	logic pwm_a;
	wire sel_mode = reg_addr == `OFF_CTRL_A || reg_addr == `OFF_CTRL_C;
	wire ev_a = count_tick && (counter_value == compare_value_a ||
		counter_value == `CNT_BOTTOM);
	wire mapped = sel_mode || reg_addr == `OFF_CTRL_D ||
		reg_addr == `OFF_STATUS;

	// shadow writes land in the same storage
	always @(posedge core_clk) begin
		if (!resetn) begin
			mode_a <= `RST_MODE;
			pwm_a <= `RST_PWM;
		end else if (reg_write && sel_mode) begin
			mode_a <= reg_wdata[`F_MODE_A_HI:`F_MODE_A_LO];
			if (reg_addr == `OFF_CTRL_A)
				pwm_a <= reg_wdata[`F_PWM_A];
		end
	end

	// ********
	// properties
	// ********
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// the release edge itself starts attempts, hence resetn below
	sequence s_read_c;
		reg_read && reg_addr == `OFF_CTRL_C;
	endsequence
	sequence s_toggle;
		!pwm_a && mode_a == `CODE_TOGGLE && count_tick &&
			counter_value == compare_value_a;
	endsequence

	rdata_idle_a:
		assert property (!reg_read |=> reg_rdata == `RST_BYTE)
		else $error("read data not zero when idle");
	unmapped_read_a:
		assert property (reg_read && !mapped |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	shadow_read_a:
		assert property (s_read_c |=> reg_rdata[7:6] == $past(mode_a))
		else $error("shadow bits differ from mode");
	oe_follow_a:
		assert property (resetn |=> compare_pin_a_oe == $past(dir_a))
		else $error("pin a enable not direction");
	oe_follow_b_a:
		assert property (resetn |=> compare_pin_b_oe == $past(dir_b))
		else $error("pin b enable not direction");
	wave_hold_a:
		assert property (!ev_a |=> $stable(waveform_out_a))
		else $error("waveform moved without event");
	toggle_match_a:
		assert property (s_toggle |=> waveform_out_a != $past(waveform_out_a))
		else $error("waveform did not toggle");
	pin_true_a:
		assert property (mode_a != `CODE_OFF |=>
			compare_pin_a == $past(waveform_out_a))
		else $error("pin a not waveform");
	pin_port_a:
		assert property (resetn && mode_a == `CODE_OFF |=>
			compare_pin_a == $past(port_data_a))
		else $error("pin a not port data");
	comp_port_a:
		assert property (resetn && (!pwm_a || mode_a == `CODE_OFF) |=>
			compare_pin_a_n == $past(port_data_a_n))
		else $error("complement pin connected");
endmodule

`default_nettype wire

// *** verif/test_timer_compare_output.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "timer_cmp_defines.vh"

module test_timer_compare_output;
	logic core_clk = 1'h0;
	logic resetn = 1'h0;
	logic [5:0] reg_addr = 6'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'h0;
	logic reg_read = 1'h0;
	logic [9:0] counter_value = 10'h000;
	logic [9:0] cmp = 10'h005;
	logic count_tick = 1'h0;
	logic count_down = 1'h0;
	logic pd = 1'h0;
	logic dir = 1'h1;
	wire [7:0] reg_rdata;
	wire pa, pa_n, pb, pb_n, oa, oa_n, ob, ob_n, wa, wb;
	int n_fail = 0;
	int samples_checked = 0;
	int cycles = 0;

	timer_compare_output dut (.core_clk(core_clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata),
		.counter_value(counter_value), .count_tick(count_tick),
		.count_down(count_down), .compare_value_a(cmp),
		.compare_value_b(cmp), .port_data_a(pd), .port_data_a_n(pd),
		.port_data_b(pd), .port_data_b_n(pd), .dir_a(dir), .dir_a_n(dir),
		.dir_b(dir), .dir_b_n(dir), .compare_pin_a(pa),
		.compare_pin_a_oe(oa), .compare_pin_a_n(pa_n),
		.compare_pin_a_n_oe(oa_n), .compare_pin_b(pb),
		.compare_pin_b_oe(ob), .compare_pin_b_n(pb_n),
		.compare_pin_b_n_oe(ob_n), .waveform_out_a(wa),
		.waveform_out_b(wb));

	initial begin
		forever #12.5 core_clk = ~core_clk;
	end

	// ********
	// checks and bus cycles
	// ********
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// hang guard, whole run is just under two hundred cycles
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_fail++;
			finish_test();
		end
	end

	task automatic chk_bit(input string n, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s exp %b got %b", n, e, g);
		end
	endtask

	task automatic chk_byte(input string n, input logic [7:0] e,
		input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'h1;
		@(posedge core_clk);
		reg_write <= 1'h0;
	endtask

	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1'h1;
		@(posedge core_clk);
		reg_read <= 1'h0;
		#1;
		chk_byte("rdata", e, reg_rdata);
	endtask

	// one counter event, then both channels judged
	task automatic run(input logic p, input logic [1:0] ws, input logic [1:0] c,
		input logic [9:0] v, input logic dn, input logic ew, input logic ecn);
		wr(`OFF_CTRL_D, {6'h00, ws});
		wr(`OFF_CTRL_A, {c, c, 2'h0, p, p});
		@(posedge core_clk);
		counter_value <= v;
		count_down <= dn;
		count_tick <= 1'h1;
		pd <= ~pd;
		@(posedge core_clk);
		count_tick <= 1'h0;
		@(posedge core_clk);
		#1;
		chk_bit("wave_a", ew, wa);
		chk_bit("wave_b", ew, wb);
		chk_bit("pin_a", c != 2'h0 ? ew : pd, pa);
		chk_bit("pin_b", c != 2'h0 ? ew : pd, pb);
		chk_bit("pin_a_n", ecn ? ~ew : pd, pa_n);
		chk_bit("pin_b_n", ecn ? ~ew : pd, pb_n);
	endtask

	// ********
	// scenarios
	// ********
	task automatic t_regs;
		rd(6'h3F, 8'h00);
		wr(`OFF_CTRL_A, 8'hE3);
		rd(`OFF_CTRL_A, 8'hE3);
		rd(`OFF_CTRL_C, 8'hE0);
		wr(`OFF_CTRL_C, 8'h5A);
		rd(`OFF_CTRL_A, 8'h53);
		rd(`OFF_CTRL_C, 8'h5A);
		wr(`OFF_CTRL_A, 8'h0C);
		rd(`OFF_CTRL_A, 8'h00);
		wr(`OFF_CTRL_C, 8'h00);
	endtask

	task automatic t_normal;
		run(1'h0, 2'h0, 2'h1, cmp, 1'h0, 1'h1, 1'h0);
		run(1'h0, 2'h0, 2'h1, cmp, 1'h0, 1'h0, 1'h0);
		run(1'h0, 2'h0, 2'h3, cmp, 1'h0, 1'h1, 1'h0);
		run(1'h0, 2'h0, 2'h2, cmp, 1'h0, 1'h0, 1'h0);
		run(1'h0, 2'h0, 2'h3, 10'h007, 1'h0, 1'h0, 1'h0);
		run(1'h0, 2'h0, 2'h0, cmp, 1'h0, 1'h0, 1'h0);
	endtask

	task automatic t_fast;
		run(1'h1, 2'h0, 2'h1, 10'h000, 1'h0, 1'h1, 1'h1);
		run(1'h1, 2'h0, 2'h1, cmp, 1'h0, 1'h0, 1'h1);
		run(1'h1, 2'h0, 2'h2, 10'h000, 1'h0, 1'h1, 1'h0);
		run(1'h1, 2'h0, 2'h3, cmp, 1'h0, 1'h1, 1'h0);
		run(1'h1, 2'h0, 2'h3, 10'h000, 1'h0, 1'h0, 1'h0);
	endtask

	task automatic t_dual;
		run(1'h1, 2'h1, 2'h1, cmp, 1'h0, 1'h0, 1'h1);
		run(1'h1, 2'h1, 2'h1, cmp, 1'h1, 1'h1, 1'h1);
		run(1'h1, 2'h1, 2'h2, cmp, 1'h0, 1'h0, 1'h0);
		run(1'h1, 2'h1, 2'h3, cmp, 1'h0, 1'h1, 1'h0);
		run(1'h1, 2'h1, 2'h3, cmp, 1'h1, 1'h0, 1'h0);
		run(1'h1, 2'h1, 2'h0, cmp, 1'h0, 1'h0, 1'h0);
	endtask

	task automatic t_six;
		run(1'h1, 2'h2, 2'h1, cmp, 1'h0, 1'h0, 1'h1);
		run(1'h1, 2'h2, 2'h3, cmp, 1'h0, 1'h1, 1'h1);
		run(1'h1, 2'h3, 2'h1, cmp, 1'h0, 1'h0, 1'h1);
		run(1'h1, 2'h3, 2'h2, cmp, 1'h1, 1'h1, 1'h1);
		run(1'h1, 2'h3, 2'h3, cmp, 1'h1, 1'h0, 1'h1);
	endtask

	// six-output takes channel B pins even with B's own mode off
	task automatic t_six_b;
		wr(`OFF_CTRL_D, 8'h02);
		wr(`OFF_CTRL_A, 8'h42);
		@(posedge core_clk);
		counter_value <= `CNT_BOTTOM;
		count_tick <= 1'h1;
		@(posedge core_clk);
		count_tick <= 1'h0;
		@(posedge core_clk);
		#1;
		chk_bit("wave_a", 1'h1, wa);
		chk_bit("wave_b", 1'h0, wb);
		chk_bit("pin_a_n", 1'h0, pa_n);
		chk_bit("pin_b", 1'h1, pb);
		chk_bit("pin_b_n", 1'h0, pb_n);
		rd(`OFF_STATUS, 8'h75);
		rd(`OFF_CTRL_D, 8'h02);
	endtask

	// direction bits are software's job
	task automatic t_dir;
		@(posedge core_clk);
		dir <= 1'h0;
		repeat (2) @(posedge core_clk);
		#1;
		chk_bit("oe_a", 1'h0, oa | oa_n);
		chk_bit("oe_b", 1'h0, ob | ob_n);
		@(posedge core_clk);
		dir <= 1'h1;
		repeat (2) @(posedge core_clk);
		#1;
		chk_bit("oe_all", 1'h1, oa & oa_n & ob & ob_n);
	endtask

	initial begin
		repeat (6) @(posedge core_clk);
		resetn <= 1'h1;
		t_regs();
		t_normal();
		t_fast();
		t_dual();
		t_six();
		t_six_b();
		t_dir();
		finish_test();
	end
endmodule

bind timer_compare_output cmp_out_checker chk (.core_clk(core_clk),
	.resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.counter_value(counter_value), .count_tick(count_tick),
	.compare_value_a(compare_value_a), .port_data_a(port_data_a),
	.port_data_a_n(port_data_a_n), .dir_a(dir_a), .dir_b(dir_b),
	.compare_pin_a(compare_pin_a), .compare_pin_a_n(compare_pin_a_n),
	.compare_pin_a_oe(compare_pin_a_oe), .compare_pin_b_oe(compare_pin_b_oe),
	.waveform_out_a(waveform_out_a));

`default_nettype wire
